// ==== rtl/tapc_regs.vh ====
// Constants of the thermal alarm and pin function configuration bank.
// Assumes inclusion by the bank module only; definitions, no logic.
`ifndef TAPC_REGS_VH
`define TAPC_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TAPC_IDX_RESP 8'h0d
`define TAPC_IDX_SRC_ONE 8'h0e
`define TAPC_IDX_SRC_TWO 8'h0f
`define TAPC_IDX_PIN_ONE 8'h10
`define TAPC_IDX_PIN_TWO 8'h11
`define TAPC_IDX_PIN_THREE 8'h12
`define TAPC_IDX_CTRL 8'h20
`define TAPC_IDX_STAT 8'h21

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TAPC_RST_RESP 8'h00
`define TAPC_RST_SRC 5'h00
`define TAPC_RST_PIN_ONE 8'h7f
`define TAPC_RST_PIN_TWO 8'hce
`define TAPC_RST_PIN_THREE 7'h21

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TAPC_BOOST_ONE 0
`define TAPC_BOOST_TWO 1
`define TAPC_WIN_ONE_LSB 2
`define TAPC_WIN_TWO_LSB 5
`define TAPC_TMR_EN 0
`define TAPC_LOCK_BIT 0
`define TAPC_SWRST_BIT 1
`define TAPC_VID_BIT 7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TAPC_CLK_HZ 100000000
`define TAPC_WIN_BASE_MS 250
`define TAPC_TICKS_PER_BASE 32
`define TAPC_WIN_MAX_CODE 3'h5

`endif

// ==== rtl/tapc_bank.v ====
// Thermal alarm and pin function configuration bank with APB slave.
// Assumes over-limit inputs come from comparators on pclk; alarm pins
// are open drain, resolved outside from the output enables.
//
// Operation
// - Boost bit 0 clear forces fans to full drive while matching alarm pin asserts.
// - Boost bit 1 set leaves fans alone on alarm two; both boost bits reset to 0.
// - Bits [7:5] choose alarm-two window: 0.25,0.5,1,2,4 s, then 8 s.
// - Bits [4:2] choose alarm-one window; code 000 is 0.25 s.
// - Alarm-one source bit 0 enables its timer; resets to 0.
// - Alarm-two source bit 0 enables its timer; resets to 0.
// - Alarm-one bit 1 pulls alarm-one pin low on local over-limit.
// - Alarm-one bits 2..4 pull pin low on remote 1..3 over-limit.
// - Alarm-two bit 1 pulls alarm-two pin low on local over-limit.
// - Alarm-two bits 2..4 pull pin low on remote 1..3; all reset 0.
// - Bits [7:5] of both source registers are reserved, read only.
// - Pin config one bit 0: 12 V monitor or fan speed input five.
// - Pin config one bits 1..4: GPIO or fan speed inputs four..one.
// - Pin config one bits 6,5: diode pair or voltage and sense inputs.
// - Pin config one bit 7 gives seven pins to voltage ID inputs.
// - Pin config two [1:0] selects one input's monitored voltage.
// - Pin config two bits 2,3,7: voltage or fan speed inputs 8,7,6.
// - Pin config two bits 4,5 pick voltage scales; both reset 0.
// - Pin config two bit 6: 3.3 V monitor or fan drive output four.
// - Pin config three bit 1: full fan request or intrusion; bit 0 reserved.
// - Pin config three [3:2],[5:4]: supply, 1.2 V or overheat input.
// - Pin config three [7:6] selects core supply two voltage scale.
// - All registers return to defaults on power-on; software reset restores all but the lock.

`timescale 1ns/1ps
`default_nettype none
`include "tapc_regs.vh"

module tapc_bank #(
    parameter integer ADDR_W = 12,
    parameter integer TICK_CYC = (`TAPC_CLK_HZ / 1000) * `TAPC_WIN_BASE_MS / `TAPC_TICKS_PER_BASE
) (
    input wire pclk, // APB clock, 100 MHz
    input wire presetn, // Power-on reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [ADDR_W-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    input wire [3:0] pstrb, // APB byte strobes
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready, always high
    output reg pslverr, // APB error on unmapped address
    input wire local_over_one, // Local above alarm-one limit
    input wire [2:0] remote_over_one, // Remotes 3..1 above alarm-one limit
    input wire local_over_two, // Local above alarm-two limit
    input wire [2:0] remote_over_two, // Remotes 3..1 above alarm-two limit
    output wire thermal_alarm_one_out, // Alarm-one pin drive value
    output wire thermal_alarm_one_oe, // Alarm-one pin driven low
    output wire thermal_alarm_two_out, // Alarm-two pin drive value
    output wire thermal_alarm_two_oe, // Alarm-two pin driven low
    output reg fan_full_drive, // Force all fans to maximum PWM
    output wire [7:0] pin_config_one, // Pin function register one
    output wire [7:0] pin_config_two, // Pin function register two
    output wire [7:0] pin_config_three, // Pin function register three
    output wire voltage_id_inputs_en, // Shared pins act as voltage ID
    output wire [7:0] fan_speed_input_en, // Fan speed inputs 8..1 enabled
    output wire fan_drive_output_four_en, // Fan drive output four enabled
    output wire full_fan_request_input_en, // Full fan request input enabled
    output wire regulator_overheat_input_one_en, // Overheat input one enabled
    output wire regulator_overheat_input_two_en, // Overheat input two enabled
    output wire config_locked // Register lock is set
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // Configuration bytes, reserved bits not stored
    reg [7:0] resp_cfg;
    reg [4:0] src_one;
    reg [4:0] src_two;
    reg [7:0] pin_one;
    reg [7:0] pin_two;
    reg [7:1] pin_three;

    // Own control state
    reg lock;
    reg sw_rst;

    // Per-alarm pin state and timer results
    wire [1:0] alarm_vec;
    wire [5:0] stat_one;
    wire [5:0] stat_two;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Word index and legal address check
    wire [7:0] idx = paddr[9:2];
    wire aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});

    // Completed access and write qualifiers
    wire access = psel && penable;
    wire wr_ok = access && pwrite && pstrb[0];
    wire cfg_wr = wr_ok && !lock;

    // Read mux outputs
    reg [31:0] rd_val;
    reg hit;

    // No wait states
    assign pready = 1'b1;

    // Read mux and address hit
    always @* begin
        rd_val = 32'h0000_0000;
        hit = aligned;
        if (idx == `TAPC_IDX_RESP) begin
            rd_val[7:0] = resp_cfg;
        end else if (idx == `TAPC_IDX_SRC_ONE) begin
            rd_val[7:0] = {3'h0, src_one};
        end else if (idx == `TAPC_IDX_SRC_TWO) begin
            rd_val[7:0] = {3'h0, src_two};
        end else if (idx == `TAPC_IDX_PIN_ONE) begin
            rd_val[7:0] = pin_one;
        end else if (idx == `TAPC_IDX_PIN_TWO) begin
            rd_val[7:0] = pin_two;
        end else if (idx == `TAPC_IDX_PIN_THREE) begin
            rd_val[7:0] = {pin_three, 1'b0};
        end else if (idx == `TAPC_IDX_CTRL) begin
            rd_val[7:0] = {7'h00, lock};
        end else if (idx == `TAPC_IDX_STAT) begin
            rd_val[15:0] = {2'h0, stat_two, 2'h0, stat_one};
        end else begin
            hit = 1'b0;
        end
    end

    // Read data and error captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            // Latched once per transfer, held through access
            prdata <= (!pwrite && hit) ? rd_val : 32'h0000_0000;
            pslverr <= !hit;
        end
    end

    // ------------------------------------------------------------------
    // Lock and software reset
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= 1'b0;
            sw_rst <= 1'b0;
        end else begin
            // Soft reset pulse, one cycle
            sw_rst <= wr_ok && aligned && (idx == `TAPC_IDX_CTRL) && pwdata[`TAPC_SWRST_BIT];

            // Lock is sticky until power-on reset
            if (wr_ok && aligned && (idx == `TAPC_IDX_CTRL) && pwdata[`TAPC_LOCK_BIT]) begin
                lock <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_cfg <= `TAPC_RST_RESP;
            src_one <= `TAPC_RST_SRC;
            src_two <= `TAPC_RST_SRC;
            pin_one <= `TAPC_RST_PIN_ONE;
            pin_two <= `TAPC_RST_PIN_TWO;
            pin_three <= `TAPC_RST_PIN_THREE;
        end else if (sw_rst) begin
            // Soft reset reloads defaults
            resp_cfg <= `TAPC_RST_RESP;
            src_one <= `TAPC_RST_SRC;
            src_two <= `TAPC_RST_SRC;
            pin_one <= `TAPC_RST_PIN_ONE;
            pin_two <= `TAPC_RST_PIN_TWO;
            pin_three <= `TAPC_RST_PIN_THREE;
        end else if (cfg_wr && aligned) begin
            // Byte 0 of the addressed word
            if (idx == `TAPC_IDX_RESP) begin
                resp_cfg <= pwdata[7:0];
            end else if (idx == `TAPC_IDX_SRC_ONE) begin
                src_one <= pwdata[4:0];
            end else if (idx == `TAPC_IDX_SRC_TWO) begin
                src_two <= pwdata[4:0];
            end else if (idx == `TAPC_IDX_PIN_ONE) begin
                pin_one <= pwdata[7:0];
            end else if (idx == `TAPC_IDX_PIN_TWO) begin
                pin_two <= pwdata[7:0];
            end else if (idx == `TAPC_IDX_PIN_THREE) begin
                pin_three <= pwdata[7:1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared tick for window timers
    // ------------------------------------------------------------------
    // Free-running divider and its strobe
    reg [31:0] tick_cnt;
    wire tick = (tick_cnt == TICK_CYC - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0000_0000;
        end else if (tick || sw_rst) begin
            // Wrap, or restart on soft reset
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Alarm pins and assertion timers, one per alarm
    // ------------------------------------------------------------------
    genvar g;

    generate
        for (g = 0; g < 2; g = g + 1) begin : alarm
            // Per-alarm source, limit and window selection
            wire [4:0] src = (g == 0) ? src_one : src_two;
            wire [3:0] over = (g == 0) ? {remote_over_one, local_over_one} : {remote_over_two, local_over_two};
            wire [2:0] code = (g == 0) ? resp_cfg[`TAPC_WIN_ONE_LSB+:3] : resp_cfg[`TAPC_WIN_TWO_LSB+:3];
            wire [2:0] k = (code > `TAPC_WIN_MAX_CODE) ? `TAPC_WIN_MAX_CODE : code;
            wire [10:0] win_last = (11'h020 << k) - 11'h001;

            // Pin state and timer counters
            reg a_q;
            reg [10:0] ticks;
            reg [10:0] hits;
            reg [5:0] stat;

            // Count including the final tick, scaled to 32nds
            wire [10:0] hits_sum = hits + {10'h000, a_q};
            wire [10:0] hits_avg = hits_sum >> k;

            // Pin pulled low while any enabled source is over limit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    a_q <= 1'b0;
                end else begin
                    a_q <= |(src[4:1] & over);
                end
            end

            // Fraction of window asserted, in 1/32 steps
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ticks <= 11'h000;
                    hits <= 11'h000;
                    stat <= 6'h00;
                end else if (sw_rst || !src[`TAPC_TMR_EN]) begin
                    // Disabled timer forgets its window
                    ticks <= 11'h000;
                    hits <= 11'h000;
                    stat <= 6'h00;
                end else if (tick) begin
                    // Window end latches the scaled count
                    if (ticks >= win_last) begin
                        ticks <= 11'h000;
                        hits <= 11'h000;
                        stat <= hits_avg[5:0];
                    end else begin
                        ticks <= ticks + 11'h001;
                        hits <= hits + {10'h000, a_q};
                    end
                end
            end

            // Route pin state and status outward
            assign alarm_vec[g] = a_q;

            if (g == 0) begin : s1
                assign stat_one = stat;
            end else begin : s2
                assign stat_two = stat;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Fan boost on asserted alarms
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_full_drive <= 1'b0;
        end else begin
            // Each alarm boosts unless its bit is set
            fan_full_drive <= (alarm_vec[0] && !resp_cfg[`TAPC_BOOST_ONE]) ||
                              (alarm_vec[1] && !resp_cfg[`TAPC_BOOST_TWO]);
        end
    end

    // ------------------------------------------------------------------
    // Pin drive and pin function decode
    // ------------------------------------------------------------------
    // Open-drain alarm pins, only ever pulled low
    assign thermal_alarm_one_out = 1'b0;
    assign thermal_alarm_one_oe = alarm_vec[0];
    assign thermal_alarm_two_out = 1'b0;
    assign thermal_alarm_two_oe = alarm_vec[1];

    // Raw register views
    assign pin_config_one = pin_one;
    assign pin_config_two = pin_two;
    assign pin_config_three = {pin_three, 1'b0};

    // Voltage ID takes priority on shared pins
    assign voltage_id_inputs_en = pin_one[`TAPC_VID_BIT];

    // Fan speed inputs one to five; one to four lost to voltage ID
    assign fan_speed_input_en[0] = pin_one[4] && !pin_one[`TAPC_VID_BIT];
    assign fan_speed_input_en[1] = pin_one[3] && !pin_one[`TAPC_VID_BIT];
    assign fan_speed_input_en[2] = pin_one[2] && !pin_one[`TAPC_VID_BIT];
    assign fan_speed_input_en[3] = pin_one[1] && !pin_one[`TAPC_VID_BIT];
    assign fan_speed_input_en[4] = pin_one[0];

    // Fan speed inputs six to eight
    assign fan_speed_input_en[5] = pin_two[7];
    assign fan_speed_input_en[6] = pin_two[3];
    assign fan_speed_input_en[7] = pin_two[2];

    // Remaining shared pin roles
    assign fan_drive_output_four_en = pin_two[6] && !pin_one[`TAPC_VID_BIT];
    assign full_fan_request_input_en = !pin_three[1];
    assign regulator_overheat_input_one_en = pin_three[5];
    assign regulator_overheat_input_two_en = pin_three[3];

    // Lock state for the outside
    assign config_locked = lock;

endmodule
`default_nettype wire

// ==== tb/tapc_bank_properties.sv ====
// Checker of the alarm and pin function bank, bound to its top module.
// Assumes one pclk domain and presetn as asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tapc_bank_chk #(
    parameter integer ADDR_W = 12
) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [ADDR_W-1:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire [3:0] pstrb, // APB strobes
    input wire pslverr, // APB error
    input wire local_over_one, // Local over limit one
    input wire [2:0] remote_over_one, // Remote over limit one
    input wire local_over_two, // Local over limit two
    input wire [2:0] remote_over_two, // Remote over limit two
    input wire thermal_alarm_one_oe, // Alarm one pulled low
    input wire thermal_alarm_two_oe, // Alarm two pulled low
    input wire fan_full_drive, // Fans at full drive
    input wire [7:0] pin_config_one, // Pin register one
    input wire [7:0] pin_config_two, // Pin register two
    input wire [7:0] pin_config_three, // Pin register three
    input wire voltage_id_inputs_en, // Voltage ID pins
    input wire [7:0] fan_speed_input_en, // Fan speed inputs
    input wire fan_drive_output_four_en, // Fan drive four
    input wire full_fan_request_input_en, // Full fan request
    input wire config_locked // Lock state
);
    // ----------------------------------------------------------------
    // Clocking and helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write of byte 0 to pin register one
    wire wr_pin1 = psel && penable && pwrite && pstrb[0] && (paddr == 'h40);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_oe_one;
        $rose(thermal_alarm_one_oe) |-> $past(local_over_one || (remote_over_one != 3'h0));
    endproperty
    a_oe_one: assert property (p_oe_one) else $error("alarm one asserted without cause");
    property p_oe_two;
        $rose(thermal_alarm_two_oe) |-> $past(local_over_two || (remote_over_two != 3'h0));
    endproperty
    a_oe_two: assert property (p_oe_two) else $error("alarm two asserted without cause");
    property p_fan;
        $rose(fan_full_drive) |-> $past(thermal_alarm_one_oe || thermal_alarm_two_oe);
    endproperty
    a_fan: assert property (p_fan) else $error("full drive without alarm");
    property p_vid;
        voltage_id_inputs_en == pin_config_one[7] && fan_drive_output_four_en == (pin_config_two[6] && !pin_config_one[7]);
    endproperty
    a_vid: assert property (p_vid) else $error("voltage id or drive four wrong");
    property p_fsi;
        fan_speed_input_en == {pin_config_two[2], pin_config_two[3], pin_config_two[7], pin_config_one[0],
            {pin_config_one[1], pin_config_one[2], pin_config_one[3], pin_config_one[4]} & {4{!pin_config_one[7]}}};
    endproperty
    a_fsi: assert property (p_fsi) else $error("fan speed enables wrong");
    property p_pin3;
        pin_config_three[0] == 1'b0 && full_fan_request_input_en == !pin_config_three[1];
    endproperty
    a_pin3: assert property (p_pin3) else $error("pin register three map wrong");
    property p_wr;
        wr_pin1 && !config_locked |=> pin_config_one == $past(pwdata[7:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("pin register one write lost");
    property p_lock;
        wr_pin1 && config_locked |=> $stable(pin_config_one) ##1 $stable(pin_config_one);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register changed");
    property p_sticky;
        config_locked |=> config_locked;
    endproperty
    a_sticky: assert property (p_sticky) else $error("lock dropped");
    c_fan: cover property (thermal_alarm_one_oe && fan_full_drive);
    c_lock: cover property (wr_pin1 && config_locked);
    c_err: cover property (pslverr);
endmodule
bind tapc_bank tapc_bank_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
    .local_over_one(local_over_one), .remote_over_one(remote_over_one), .local_over_two(local_over_two),
    .remote_over_two(remote_over_two), .thermal_alarm_one_oe(thermal_alarm_one_oe),
    .thermal_alarm_two_oe(thermal_alarm_two_oe), .fan_full_drive(fan_full_drive),
    .pin_config_one(pin_config_one), .pin_config_two(pin_config_two), .pin_config_three(pin_config_three),
    .voltage_id_inputs_en(voltage_id_inputs_en), .fan_speed_input_en(fan_speed_input_en),
    .fan_drive_output_four_en(fan_drive_output_four_en), .full_fan_request_input_en(full_fan_request_input_en),
    .config_locked(config_locked));
`default_nettype wire

// ==== tb/tapc_bank_tb.sv ====
// Self-checking bench of the alarm and pin function bank over APB.
// Assumes the bank answers with zero wait states; short timer ticks.
`timescale 1ns/1ps
`default_nettype none
module tapc_bank_tb;
    localparam integer TICK = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, err, lo1 = 0, lo2 = 0, a1o, a1e, a2o, a2e, fan, vid, f4, ffr, ro1, ro2, lck;
    logic [2:0] rm1 = 0, rm2 = 0;
    logic [7:0] p1, p2, p3, fsi;
    int err_count = 0, n_tests = 0, cyc = 0;
    tapc_bank #(.TICK_CYC(TICK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .local_over_one(lo1), .remote_over_one(rm1), .local_over_two(lo2),
        .remote_over_two(rm2), .thermal_alarm_one_out(a1o), .thermal_alarm_one_oe(a1e),
        .thermal_alarm_two_out(a2o), .thermal_alarm_two_oe(a2e), .fan_full_drive(fan), .pin_config_one(p1),
        .pin_config_two(p2), .pin_config_three(p3), .voltage_id_inputs_en(vid), .fan_speed_input_en(fsi),
        .fan_drive_output_four_en(f4), .full_fan_request_input_en(ffr), .regulator_overheat_input_one_en(ro1),
        .regulator_overheat_input_two_en(ro2), .config_locked(lck));
    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #5 pclk = ~pclk;
    // Cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            close_out();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Let n edges pass; outputs are then read before this edge's updates
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    logic [11:0] adr [6] = '{12'h034, 12'h038, 12'h03c, 12'h040, 12'h044, 12'h048};
    logic [7:0] dflt [6] = '{8'h00, 8'h00, 8'h00, 8'h7f, 8'hce, 8'h42};
    logic [7:0] ones [6] = '{8'hff, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'hfe};
    task automatic t_defaults();
        for (int i = 0; i < 6; i++) begin
            apb(0, adr[i], 0, 4'h0);
            check("default", rd, {24'h0, dflt[i]});
        end
        check("outputs", {a1e, a2e, fan, p3}, {3'b000, 8'h42});
        $display("test defaults done");
    endtask
    task automatic t_access();
        for (int i = 0; i < 6; i++) begin
            apb(1, adr[i], 32'hffff_ffff, 4'hf);
            apb(0, adr[i], 0, 4'h0);
            check("all ones", rd, {24'h0, ones[i]});
        end
        apb(1, 12'h040, 32'h0000_0000, 4'h0);
        apb(0, 12'h040, 0, 4'h0);
        check("no strobe", rd, 32'h0000_00ff);
        apb(0, 12'h04c, 0, 4'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test access done");
    endtask
    task automatic t_alarm();
        apb(1, 12'h034, 32'h0, 4'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h038, 32'h1 << (i + 1), 4'h1);
            apb(1, 12'h03c, 32'h1 << (i + 1), 4'h1);
            lo1 <= (i == 0); lo2 <= (i == 0);
            rm1 <= (i == 0) ? 3'h0 : 3'h1 << (i - 1); rm2 <= (i == 0) ? 3'h0 : 3'h1 << (i - 1);
            settle(3);
            check("alarm on", {29'h0, a1e, a2e, fan}, 32'h7);
            lo1 <= (i != 0); lo2 <= (i != 0);
            rm1 <= (i == 0) ? 3'h7 : ~(3'h1 << (i - 1)); rm2 <= (i == 0) ? 3'h7 : ~(3'h1 << (i - 1));
            settle(3);
            check("alarm other", {29'h0, a1e, a2e, fan}, 32'h0);
        end
        apb(1, 12'h034, 32'h3, 4'h1);
        lo1 <= 0; lo2 <= 0; rm1 <= 3'h4; rm2 <= 3'h4;
        settle(3);
        check("boost off", {29'h0, a1e, a2e, fan}, 32'h6);
        rm1 <= 0; rm2 <= 0;
        $display("test alarm done");
    endtask
    // Full-duty alarm over two windows reads 32 of 32 steps
    task automatic t_window(input logic [2:0] c);
        apb(1, 12'h034, {24'h0, c, c, 2'b00}, 4'h1);
        apb(1, 12'h038, 32'h3, 4'h1);
        apb(1, 12'h03c, 32'h3, 4'h1);
        lo1 <= 1; lo2 <= 1;
        repeat (2 * (32 << ((c > 5) ? 5 : c)) * TICK + 20) @(posedge pclk);
        apb(0, 12'h084, 0, 4'h0);
        check("window", rd & 32'h3f3f, 32'h2020);
        apb(1, 12'h038, 32'h2, 4'h1);
        apb(1, 12'h03c, 32'h2, 4'h1);
        apb(0, 12'h084, 0, 4'h0);
        check("timer off", rd & 32'h3f3f, 32'h0);
        lo1 <= 0; lo2 <= 0;
        $display("test window %0d done", c);
    endtask
    task automatic t_reset_lock();
        apb(1, 12'h040, 32'haa, 4'h1);
        apb(1, 12'h080, 32'h2, 4'h1);
        apb(0, 12'h040, 0, 4'h0);
        check("soft reset", rd, 32'h7f);
        apb(1, 12'h080, 32'h1, 4'h1);
        apb(1, 12'h044, 32'h00, 4'h1);
        apb(0, 12'h044, 0, 4'h0);
        check("locked", {lck, rd[7:0]}, 9'h1ce);
        $display("test reset and lock done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_defaults();
        t_access();
        t_alarm();
        t_window(3'h0);
        t_window(3'h1);
        t_window(3'h6);
        t_reset_lock();
        close_out();
    end
endmodule
`default_nettype wire
